// ### rtl/lsc_scan.sv
// Display scan address generator and cursor control with AXI4-Lite registers
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
// Behaviour
// - Bitmap origin top-left, bits are neighbouring pixels
// - Cell grows by horizontal and vertical size
// - Character width up to sixteen pixels
// - Graphics uses eight times text memory
// - Scan left to right, rows top down
// - Graphics line start adds address pitch
// - Text rereads line, then adds pitch
// - Text byte holds one character code
// - Byte gives eight, four, two pixels
// - Dual panel fetches upper then lower line
// - Line end idles total minus active slots
// - Dual panel pulses line after lower screen
// - Cursor address is also access address
// - Access steps cursor by direction once per cycle, cursor write wins
// - Cursor layer one or three by overlay
// - Cursor hidden outside its layer region
// - Dummy cursor only graphics shown, text off
// - No text screen gives bar cursor
// - Mixed layer block: block text, bar graphics
module lsc_scan
  import lsc_pkg::*;
#(
  parameter int LINE_W = 16
)(
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic [11:0] awaddr_in,
  input  wire logic        awvalid_in,
  output logic             awready_out,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  wstrb_in,
  input  wire logic        wvalid_in,
  output logic             wready_out,
  output logic [1:0]       bresp_out,
  output logic             bvalid_out,
  input  wire logic        bready_in,
  input  wire logic [11:0] araddr_in,
  input  wire logic        arvalid_in,
  output logic             arready_out,
  output logic [31:0]      rdata_out,
  output logic [1:0]       rresp_out,
  output logic             rvalid_out,
  input  wire logic        rready_in,
  input  wire logic [7:0]  mem_data_in,
  input  wire logic [15:0] glyph_row_in,
  output logic             mem_rd_out,
  output logic [15:0]      mem_addr_out,
  output logic             mem_lower_out,
  output logic [7:0]       char_code_out,
  output logic [3:0]       char_row_out,
  output logic [3:0]       pixel_out,
  output logic             pixel_valid_out,
  output logic             panel_line_pulse_out,
  output logic [15:0]      cursor_addr_out,
  output logic             cursor_visible_out,
  output logic             cursor_block_out,
  output logic             cursor_layer3_out,
  output logic             cursor_hit_out
);

  if (LINE_W < 1 || LINE_W > 16)
  begin : g_chk
    $error("LINE_W must lie in 1..16");
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
      begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Pixels per slot: text cell width, or pixels packed in one byte
  function automatic logic [4:0] slot_len(input lsc_cfg_t c, input logic [3:0] hs);
    if (c.text_mode)
      return {1'b0, hs} + 5'h01;
    else if (c.bpp == BPP_1)
      return 5'h08;
    else if (c.bpp == BPP_2)
      return 5'h04;
    else
      return 5'h02;
  endfunction

  function automatic logic [15:0] cursor_step(input logic [15:0] a, input logic [1:0] d,
                                              input logic [15:0] p);
    case (d)
      DIR_RIGHT: return a + 16'h0001;
      DIR_LEFT:  return a - 16'h0001;
      DIR_UP:    return a - p;
      default:   return a + p;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Registers and AXI4-Lite slave
  // ----------------------------------------------------------------
  lsc_cfg_t    cfg;
  logic [3:0]  hsize;
  logic [3:0]  vsize;
  logic [7:0]  chars_row;
  logic [7:0]  total_row;
  logic [15:0] pitch;
  logic [15:0] start_up;
  logic [15:0] start_lo;
  logic [15:0] lines;
  logic [1:0]  cursor_dir;
  logic [31:0] layer1;
  logic [31:0] layer3;
  logic [15:0] text_end;
  logic        aw_got;
  logic        w_got;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic        rd_fire;
  logic        access;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic        wr_hit;
  lsc_state_t  state;
  logic        lower;
  logic [3:0]  row_idx;
  logic [LINE_W-1:0] line_cnt;

  assign wr_fire = aw_got && w_got && !bvalid_out;
  assign rd_fire = arvalid_in && arready_out;
  // Reading or writing the data window is one display memory access
  assign access  = (wr_fire && aw_addr == OFS_MEM_ACCESS) ||
                   (rd_fire && araddr_in == OFS_MEM_ACCESS);
  assign wr_hit  = aw_addr <= OFS_MEM_ACCESS && aw_addr[1:0] == 2'h0;

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      aw_got      <= 1'b0;
      w_got       <= 1'b0;
      aw_addr     <= 12'h000;
      w_data      <= 32'h0000_0000;
      w_strb      <= 4'h0;
      awready_out <= 1'b0;
      wready_out  <= 1'b0;
      bvalid_out  <= 1'b0;
      bresp_out   <= RESP_OKAY;
    end
    else
    begin
      if (awvalid_in && awready_out)
      begin
        aw_got      <= 1'b1;
        aw_addr     <= awaddr_in;
        awready_out <= 1'b0;
      end
      else if (!aw_got && !bvalid_out)
      begin
        awready_out <= 1'b1;
      end
      if (wvalid_in && wready_out)
      begin
        w_got      <= 1'b1;
        w_data     <= wdata_in;
        w_strb     <= wstrb_in;
        wready_out <= 1'b0;
      end
      else if (!w_got && !bvalid_out)
      begin
        wready_out <= 1'b1;
      end
      if (wr_fire)
      begin
        aw_got     <= 1'b0;
        w_got      <= 1'b0;
        bvalid_out <= 1'b1;
        bresp_out  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_out && bready_in)
      begin
        bvalid_out <= 1'b0;
      end
    end
  end

  always_comb
  begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    case (araddr_in)
      OFS_CTRL:       rd_word[CTRL_W-1:0] = cfg;
      OFS_CHAR_SIZE:  rd_word[VSIZE_LSB+3:0] = {vsize, 4'h0, hsize};
      OFS_CHARS_ROW:  rd_word[7:0] = chars_row;
      OFS_TOTAL_ROW:  rd_word[7:0] = total_row;
      OFS_PITCH:      rd_word[15:0] = pitch;
      OFS_START_UP:   rd_word[15:0] = start_up;
      OFS_START_LO:   rd_word[15:0] = start_lo;
      OFS_LINES:      rd_word[15:0] = lines;
      OFS_CURSOR:     rd_word[15:0] = cursor_addr_out;
      OFS_CURSOR_DIR: rd_word[1:0] = cursor_dir;
      OFS_LAYER1:     rd_word = layer1;
      OFS_LAYER3:     rd_word = layer3;
      OFS_TEXT_END:   rd_word[15:0] = text_end;
      OFS_MEM_ACCESS: rd_word[15:0] = cursor_addr_out;
      OFS_STATUS:     rd_word = {row_idx, lower, state, 8'h00, 16'(line_cnt)};
      default:        rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      arready_out <= 1'b0;
      rvalid_out  <= 1'b0;
      rdata_out   <= 32'h0000_0000;
      rresp_out   <= RESP_OKAY;
    end
    else if (rd_fire)
    begin
      arready_out <= 1'b0;
      rvalid_out  <= 1'b1;
      rdata_out   <= rd_word;
      rresp_out   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_out && rready_in)
    begin
      rvalid_out <= 1'b0;
    end
    else if (!rvalid_out)
    begin
      arready_out <= 1'b1;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      cfg        <= lsc_cfg_t'(RST_CTRL);
      hsize      <= RST_HSIZE;
      vsize      <= RST_VSIZE;
      chars_row  <= RST_CHARS_ROW;
      total_row  <= RST_TOTAL_ROW;
      pitch      <= RST_PITCH;
      start_up   <= 16'h0000;
      start_lo   <= 16'h0000;
      lines      <= RST_LINES;
      cursor_dir <= DIR_RIGHT;
      layer1     <= RST_LAYER1;
      layer3     <= RST_LAYER3;
      text_end   <= 16'h0000;
    end
    else if (wr_fire)
    begin
      case (aw_addr)
        OFS_CTRL:       cfg <= lsc_cfg_t'(CTRL_W'(wmerge(32'(cfg), w_data, w_strb)));
        OFS_CHAR_SIZE:
        begin
          hsize <= 4'(wmerge({20'h0, vsize, 4'h0, hsize}, w_data, w_strb));
          vsize <= 4'(wmerge({20'h0, vsize, 4'h0, hsize}, w_data, w_strb) >> VSIZE_LSB);
        end
        OFS_CHARS_ROW:  chars_row <= 8'(wmerge({24'h0, chars_row}, w_data, w_strb));
        OFS_TOTAL_ROW:  total_row <= 8'(wmerge({24'h0, total_row}, w_data, w_strb));
        OFS_PITCH:      pitch <= 16'(wmerge({16'h0, pitch}, w_data, w_strb));
        OFS_START_UP:   start_up <= 16'(wmerge({16'h0, start_up}, w_data, w_strb));
        OFS_START_LO:   start_lo <= 16'(wmerge({16'h0, start_lo}, w_data, w_strb));
        OFS_LINES:      lines <= 16'(wmerge({16'h0, lines}, w_data, w_strb));
        OFS_CURSOR_DIR: cursor_dir <= 2'(wmerge({30'h0, cursor_dir}, w_data, w_strb));
        OFS_LAYER1:     layer1 <= wmerge(layer1, w_data, w_strb);
        OFS_LAYER3:     layer3 <= wmerge(layer3, w_data, w_strb);
        OFS_TEXT_END:   text_end <= 16'(wmerge({16'h0, text_end}, w_data, w_strb));
        default:        cfg <= cfg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Scan sequencer
  // ----------------------------------------------------------------
  logic [4:0]  pix_cnt;
  logic [7:0]  slot_cnt;
  logic [15:0] scan_addr;
  logic [15:0] line_up;
  logic [15:0] line_lo;
  logic        slot_end;
  logic        phase_end;
  logic        line_done;
  logic        frame_end;
  logic        rd_issue;
  logic [15:0] next_up;
  logic [15:0] next_lo;
  logic [3:0]  next_row;

  // Idle state never ends a slot, so a one-pixel slot cannot fake a line end there
  assign slot_end  = state != ST_OFF && pix_cnt == slot_len(cfg, hsize) - 5'h01;
  assign phase_end = slot_end && (state == ST_PAUSE ? slot_cnt == total_row - 8'h01 :
                     (slot_cnt == chars_row - 8'h01 && total_row <= chars_row));
  assign line_done = phase_end && (!cfg.dual || lower);
  assign frame_end = line_cnt == LINE_W'(lines - 16'h0001);
  assign rd_issue  = state == ST_SCAN && pix_cnt == 5'h00 && cfg.enable;

  // Text lines reuse the start address per bitmap row; graphics add the pitch each line
  always_comb
  begin
    next_up  = line_up;
    next_lo  = line_lo;
    next_row = row_idx;
    if (frame_end)
    begin
      next_up  = start_up;
      next_lo  = start_lo;
      next_row = 4'h0;
    end
    else if (!cfg.text_mode)
    begin
      next_up = line_up + pitch;
      next_lo = line_lo + pitch;
    end
    else if (row_idx == vsize)
    begin
      next_up  = line_up + pitch;
      next_lo  = line_lo + pitch;
      next_row = 4'h0;
    end
    else
    begin
      next_row = row_idx + 4'h1;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in || !cfg.enable)
    begin
      state                <= ST_OFF;
      pix_cnt              <= 5'h00;
      slot_cnt             <= 8'h00;
      scan_addr            <= 16'h0000;
      line_up              <= 16'h0000;
      line_lo              <= 16'h0000;
      lower                <= 1'b0;
      row_idx              <= 4'h0;
      line_cnt             <= '0;
      mem_rd_out           <= 1'b0;
      mem_addr_out         <= 16'h0000;
      mem_lower_out        <= 1'b0;
      panel_line_pulse_out <= 1'b0;
    end
    else
    begin
      mem_rd_out           <= rd_issue;
      panel_line_pulse_out <= 1'b0;
      if (rd_issue)
      begin
        mem_addr_out  <= scan_addr;
        mem_lower_out <= lower;
        scan_addr     <= scan_addr + 16'h0001;
      end
      case (state)
        ST_OFF:
        begin
          state     <= ST_SCAN;
          line_up   <= start_up;
          line_lo   <= start_lo;
          scan_addr <= start_up;
        end
        ST_SCAN, ST_PAUSE:
        begin
          pix_cnt <= slot_end ? 5'h00 : pix_cnt + 5'h01;
          if (slot_end)
          begin
            slot_cnt <= slot_cnt + 8'h01;
          end
          if (state == ST_SCAN && slot_end && slot_cnt == chars_row - 8'h01 &&
              total_row > chars_row)
          begin
            state <= ST_PAUSE;
          end
          if (phase_end)
          begin
            slot_cnt <= 8'h00;
            state    <= ST_SCAN;
            if (!line_done)
            begin
              lower     <= 1'b1;
              scan_addr <= line_lo;
            end
            else
            begin
              panel_line_pulse_out <= 1'b1;
              lower                <= 1'b0;
              line_up              <= next_up;
              line_lo              <= next_lo;
              row_idx              <= next_row;
              scan_addr            <= next_up;
              line_cnt             <= frame_end ? '0 : line_cnt + 1'b1;
            end
          end
        end
        default: state <= ST_OFF;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pixel unpacking: memory answers in the same cycle as the read strobe
  // ----------------------------------------------------------------
  logic [4:0] col;
  logic       emit;

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      char_code_out   <= 8'h00;
      char_row_out    <= 4'h0;
      col             <= 5'h00;
      emit            <= 1'b0;
      pixel_out       <= 4'h0;
      pixel_valid_out <= 1'b0;
    end
    else
    begin
      pixel_valid_out <= emit;
      if (!emit)
        pixel_out <= 4'h0;
      else if (cfg.text_mode)
        pixel_out <= {3'h0, glyph_row_in[4'hF - col[3:0]]};
      else if (cfg.bpp == BPP_1)
        pixel_out <= {3'h0, char_code_out[3'h7 - col[2:0]]};
      else if (cfg.bpp == BPP_2)
        pixel_out <= {2'h0, char_code_out[3'h6 - {col[1:0], 1'b0} +: 2]};
      else
        pixel_out <= col[0] ? char_code_out[3:0] : char_code_out[7:4];
      if (emit)
      begin
        col  <= col + 5'h01;
        emit <= col != slot_len(cfg, hsize) - 5'h01;
      end
      if (mem_rd_out)
      begin
        char_code_out <= mem_data_in;
        char_row_out  <= row_idx;
        col           <= 5'h00;
        emit          <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Cursor
  // ----------------------------------------------------------------
  logic [31:0] layer_rng;
  logic        in_range;

  assign layer_rng = cfg.overlay3 ? layer3 : layer1;
  assign in_range  = cursor_addr_out >= layer_rng[15:0] && cursor_addr_out <= layer_rng[31:16];

  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      cursor_addr_out <= 16'h0000;
    end
    else if (wr_fire && aw_addr == OFS_CURSOR)
    begin
      cursor_addr_out <= 16'(wmerge({16'h0, cursor_addr_out}, w_data, w_strb));
    end
    else if (access)
    begin
      cursor_addr_out <= cursor_step(cursor_addr_out, cursor_dir, pitch);
    end
  end

  // Visibility is judged from the address, the enable bit and the screen enables; outside the layer range the cursor is hidden
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      cursor_visible_out <= 1'b0;
      cursor_block_out   <= 1'b0;
      cursor_layer3_out  <= 1'b0;
      cursor_hit_out     <= 1'b0;
    end
    else
    begin
      cursor_layer3_out  <= cfg.overlay3;
      cursor_visible_out <= cfg.enable && in_range && (cfg.text_on || cfg.gfx_on);
      cursor_block_out   <= cfg.block_sel && cfg.text_on &&
                            (!cfg.mixed || cursor_addr_out < text_end);
      cursor_hit_out     <= rd_issue && cfg.enable && in_range &&
                            scan_addr == cursor_addr_out;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  line_after_lower_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    panel_line_pulse_out && $past(cfg.dual) |-> $past(lower) && !lower)
    else $error("line pulse outside lower screen");
  gfx_pitch_add_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    line_done && !frame_end && !cfg.text_mode && cfg.enable |=>
    line_up == $past(line_up) + $past(pitch))
    else $error("graphics line start not advanced by pitch");
  text_reread_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    line_done && !frame_end && cfg.text_mode && row_idx != vsize && cfg.enable |=>
    line_up == $past(line_up) && row_idx == $past(row_idx) + 4'h1)
    else $error("text row not reread");
  pause_no_read_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    state == ST_PAUSE && $past(state) == ST_PAUSE |-> !mem_rd_out)
    else $error("read during line end pause");
  scan_step_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    rd_issue && slot_cnt != 8'h00 |=> mem_addr_out == $past(mem_addr_out) + 16'h0001)
    else $error("scan address not stepping by one");
  cursor_step_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    access && cursor_dir == DIR_RIGHT && !(wr_fire && aw_addr == OFS_CURSOR) |=>
    cursor_addr_out == $past(cursor_addr_out) + 16'h0001)
    else $error("cursor did not step");
  cursor_bar_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !$past(cfg.text_on) |-> !cursor_block_out)
    else $error("block cursor without text screen");
  cursor_range_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    cursor_visible_out |-> $past(in_range))
    else $error("cursor shown outside its layer");
  row_reset_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    line_done && cfg.text_mode && row_idx == vsize && cfg.enable |=> row_idx == 4'h0)
    else $error("row index not reset at new text line");

endmodule

// ### rtl/lsc_pkg.sv
// Package: register map, field layout, reset values and types of the LCD scan block
package lsc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL       = 12'h000;
  localparam logic [11:0] OFS_CHAR_SIZE  = 12'h004;
  localparam logic [11:0] OFS_CHARS_ROW  = 12'h008;
  localparam logic [11:0] OFS_TOTAL_ROW  = 12'h00C;
  localparam logic [11:0] OFS_PITCH      = 12'h010;
  localparam logic [11:0] OFS_START_UP   = 12'h014;
  localparam logic [11:0] OFS_START_LO   = 12'h018;
  localparam logic [11:0] OFS_LINES      = 12'h01C;
  localparam logic [11:0] OFS_CURSOR     = 12'h020;
  localparam logic [11:0] OFS_CURSOR_DIR = 12'h024;
  localparam logic [11:0] OFS_LAYER1     = 12'h028;
  localparam logic [11:0] OFS_LAYER3     = 12'h02C;
  localparam logic [11:0] OFS_TEXT_END   = 12'h030;
  localparam logic [11:0] OFS_MEM_ACCESS = 12'h034;
  localparam logic [11:0] OFS_STATUS     = 12'h038;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          CTRL_W         = 10;
  localparam int          VSIZE_LSB      = 8;
  localparam logic [9:0]  RST_CTRL       = 10'h000;
  localparam logic [3:0]  RST_HSIZE      = 4'h7;
  localparam logic [3:0]  RST_VSIZE      = 4'h7;
  localparam logic [7:0]  RST_CHARS_ROW  = 8'h28;
  localparam logic [7:0]  RST_TOTAL_ROW  = 8'h2A;
  localparam logic [15:0] RST_PITCH      = 16'h0028;
  localparam logic [15:0] RST_LINES      = 16'h00F0;
  localparam logic [31:0] RST_LAYER1     = 32'h7FFF_0000;
  localparam logic [31:0] RST_LAYER3     = 32'hFFFF_8000;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0]  BPP_1          = 2'h0;
  localparam logic [1:0]  BPP_2          = 2'h1;
  localparam logic [1:0]  DIR_RIGHT      = 2'h0;
  localparam logic [1:0]  DIR_LEFT       = 2'h1;
  localparam logic [1:0]  DIR_UP         = 2'h2;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef struct packed {
    logic       gfx_on;
    logic       text_on;
    logic       enable;
    logic       block_sel;
    logic       mixed;
    logic       overlay3;
    logic [1:0] bpp;
    logic       dual;
    logic       text_mode;
  } lsc_cfg_t;

  typedef enum logic [2:0] {
    ST_OFF   = 3'b001,
    ST_SCAN  = 3'b010,
    ST_PAUSE = 3'b100
  } lsc_state_t;

endpackage

// ### tb/lsc_mem_model.sv
// Display memory and glyph source standing at the far side of the scan block
`timescale 1ns/100ps
module lsc_mem_model
  import lsc_pkg::*;
(
  input  wire logic [15:0] mem_addr_in,
  input  wire logic [7:0]  char_code_in,
  input  wire logic [3:0]  char_row_in,
  output logic [7:0]       mem_data_out,
  output logic [15:0]      glyph_row_out
);
  // Byte follows the address so a wrong fetch shows up downstream
  assign mem_data_out  = mem_addr_in[7:0] ^ 8'hA5;
  // Two-byte rows carry code and row index, so a stale row is visible
  assign glyph_row_out = {char_code_in, 4'h0, char_row_in};
endmodule

// ### tb/lsc_scan_tb_top.sv
// Testbench for the scan block: registers, cursor stepping and scan order
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module lsc_scan_tb_top;
  import lsc_pkg::*;
  logic        clock_in = 0, rst_n_in = 0, awvalid_in = 0, wvalid_in = 0, bready_in = 0;
  logic        arvalid_in = 0, rready_in = 0;
  logic [11:0] awaddr_in = 12'h000, araddr_in = 12'h000;
  logic [31:0] wdata_in = 32'h0, rdata_out, d;
  logic [3:0]  wstrb_in = 4'hF, char_row_out, pixel_out;
  logic [7:0]  mem_data_in, char_code_out;
  logic [15:0] glyph_row_in, mem_addr_out, cursor_addr_out;
  logic [1:0]  bresp_out, rresp_out, r;
  logic        awready_out, wready_out, bvalid_out, arready_out, rvalid_out, mem_rd_out;
  logic        mem_lower_out, pixel_valid_out, panel_line_pulse_out, cursor_visible_out;
  logic        cursor_block_out, cursor_layer3_out, cursor_hit_out;
  int          n_fail = 0, checks_done = 0, cyc = 0, np = 0;
  logic [16:0] fa[$];
  int          ft[$];
  logic [3:0]  px[$];
  logic [7:0]  eb = 8'hA5;
  logic [2:0]  cl;
  // Reset table: offset beside expected value
  logic [11:0] ra[8] = '{OFS_CTRL, OFS_CHAR_SIZE, OFS_CHARS_ROW, OFS_TOTAL_ROW,
                         OFS_PITCH, OFS_LINES, OFS_LAYER1, OFS_LAYER3};
  logic [31:0] rv[8] = '{32'h0, 32'h0707, 32'h28, 32'h2A, 32'h28, 32'hF0,
                         32'h7FFF_0000, 32'hFFFF_8000};
  // Cursor table: step direction beside resulting address (pitch 0x10)
  logic [15:0] ce[4] = '{16'h0101, 16'h0100, 16'h00F0, 16'h0100};
  logic [15:0] eg[7] = '{16'h0200, 16'h0201, 16'h0202, 16'h0210, 16'h0211, 16'h0212, 16'h0220};
  logic [15:0] et[7] = '{16'h0200, 16'h0201, 16'h0202, 16'h0200, 16'h0201, 16'h0202, 16'h0210};
  // Dual panel: upper line, lower line (bit 16 marks lower), next upper line
  logic [16:0] ed[7] = '{17'h0200, 17'h0201, 17'h0202, 17'h1_0400, 17'h1_0401,
                         17'h1_0402, 17'h0210};
  // Cursor look table: control word beside {visible, layer3, block}
  logic [31:0] cc[4] = '{32'h1C0, 32'h1D0, 32'h2C0, 32'h1E0};
  logic [2:0]  cx[4] = '{3'b101, 3'b011, 3'b100, 3'b100};
  lsc_scan uut (.*);
  lsc_mem_model mem (.mem_addr_in(mem_addr_out), .char_code_in(char_code_out),
    .char_row_in(char_row_out), .mem_data_out(mem_data_in), .glyph_row_out(glyph_row_in));
  assign cl = {cursor_visible_out, cursor_layer3_out, cursor_block_out};
  always #10 clock_in = ~clock_in;
  always @(posedge clock_in)
  begin
    cyc++;
    if (mem_rd_out === 1'b1)
    begin
      fa.push_back({mem_lower_out, mem_addr_out});
      ft.push_back(cyc);
    end
    if (pixel_valid_out === 1'b1)
      px.push_back(pixel_out);
    if (panel_line_pulse_out === 1'b1)
      np++;
  end
  // ----------------------------------------------------------------
  // Bus tasks and closing
  // ----------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clock_in);
    awaddr_in <= a; wdata_in <= v; awvalid_in <= 1'b1; wvalid_in <= 1'b1; bready_in <= 1'b1;
    fork
      begin do @(posedge clock_in); while (awready_out !== 1'b1); awvalid_in <= 1'b0; end
      begin do @(posedge clock_in); while (wready_out !== 1'b1); wvalid_in <= 1'b0; end
    join
    while (bvalid_out !== 1'b1) @(posedge clock_in);
    r = bresp_out;
    bready_in <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clock_in);
    araddr_in <= a; arvalid_in <= 1'b1; rready_in <= 1'b1;
    do @(posedge clock_in); while (arready_out !== 1'b1);
    arvalid_in <= 1'b0;
    do @(posedge clock_in); while (rvalid_out !== 1'b1);
    d = rdata_out;
    r = rresp_out;
    rready_in <= 1'b0;
  endtask
  // Starts a scan and waits for n fetches; the limit keeps a stuck scanner from hanging
  task automatic scan(input logic [31:0] c, input int n);
    wr(OFS_CTRL, 32'h0);
    // A fetch launched just before the disable would otherwise land in the new log
    @(posedge clock_in);
    fa.delete();
    ft.delete();
    px.delete();
    np = 0;
    wr(OFS_CTRL, c);
    for (int i = 0; i < 2000 && fa.size() < n; i++) @(posedge clock_in);
  endtask
  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #400_000;
    n_fail++;
    close_out();
  end
  initial
  begin
    repeat (8) @(posedge clock_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      rd(ra[i]);
      `CHK("reset value", rv[i], d)
    end
    $display("reset values done");
    rd(12'h03C);
    `CHK("unmapped read resp", RESP_SLVERR, r)
    `CHK("unmapped read data", 32'h0, d)
    wr(12'h002, 32'hFFFF_FFFF);
    `CHK("unaligned write resp", RESP_SLVERR, r)
    $display("refusals done");
    wr(OFS_PITCH, 32'h10);
    wr(OFS_CURSOR, 32'h0100);
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_CURSOR_DIR, i);
      wr(OFS_MEM_ACCESS, 32'h5A);
      rd(OFS_CURSOR);
      `CHK("cursor step", {16'h0, ce[i]}, d)
      `CHK("cursor port", ce[i], cursor_addr_out)
    end
    $display("cursor done");
    wr(OFS_CHARS_ROW, 32'h3);
    wr(OFS_TOTAL_ROW, 32'h5);
    wr(OFS_START_UP, 32'h0200);
    wr(OFS_LINES, 32'h10);
    scan(32'h280, 7);
    for (int i = 0; i < 7; i++)
      `CHK("graphics fetch", eg[i], fa[i])
    // One byte per 8-pixel slot, two idle slots at each line end
    `CHK("slot gap", 8, ft[1] - ft[0])
    `CHK("line end gap", 24, ft[3] - ft[2])
    for (int i = 0; i < 8; i++)
      `CHK("gfx pixel", {3'h0, eb[7 - i]}, px[i])
    `CHK("line pulses", 2, np)
    $display("graphics scan done");
    wr(OFS_START_LO, 32'h0400);
    scan(32'h282, 7);
    for (int i = 0; i < 7; i++)
      `CHK("dual fetch", ed[i], fa[i])
    `CHK("dual line pulses", 1, np)
    $display("dual scan done");
    wr(OFS_CHAR_SIZE, 32'h0100);
    scan(32'h181, 7);
    for (int i = 0; i < 7; i++)
      `CHK("text fetch", et[i], fa[i])
    $display("text scan done");
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_CTRL, cc[i]);
      @(posedge clock_in);
      `CHK("cursor look", cx[i], cl)
    end
    $display("cursor look done");
    close_out();
  end
endmodule
